//--- logic/ccsb_nib_seq.sv
`timescale 1ns/10ps
// ==========================================================================
// Nibble sequencer: walks through the low and high halves of four bit slots.
module ccsb_nib_seq #(
   parameter int STEPS = ccsb_pkg::NIB_STEPS,
   parameter int CNT_W = ccsb_pkg::NIB_CNT_W
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Control.
   input wire logic start,
   // Status.
   output logic busy,
   output logic [CNT_W-1:0] step,
   output logic last
);
   ccsb_pkg::ccsb_seq_e state_r;
   ccsb_pkg::ccsb_seq_e state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // A start while running is ignored so a nibble is never cut short.
   assign last = (state_r == ccsb_pkg::CCSB_SEQ_RUN) && (cnt_r == CNT_W'(STEPS - 1));
   assign busy = (state_r == ccsb_pkg::CCSB_SEQ_RUN);
   assign step = cnt_r;

   // Next state and count.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ccsb_pkg::CCSB_SEQ_IDLE: begin
            cnt_nxt = '0;
            if (start) begin
               state_nxt = ccsb_pkg::CCSB_SEQ_RUN;
            end
         end
         ccsb_pkg::CCSB_SEQ_RUN: begin
            if (last) begin
               state_nxt = ccsb_pkg::CCSB_SEQ_IDLE;
               cnt_nxt = '0;
            end else begin
               cnt_nxt = cnt_r + CNT_W'(1);
            end
         end
         default: begin
            state_nxt = ccsb_pkg::CCSB_SEQ_IDLE;
            cnt_nxt = '0;
         end
      endcase
   end

   // State registers.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= ccsb_pkg::CCSB_SEQ_IDLE;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule // ccsb_nib_seq

//--- logic/ccsb_pkg.sv
// ==========================================================================
// Shared constants for the cell sideband ports.
package ccsb_pkg;
   // Bits in one flow-control nibble.
   localparam int NIB_BITS = 4;
   // Clock cycles per half period of the nibble port clocks.
   localparam int NIB_HALF_CYC = 1;
   // Sequencer steps per nibble: one low and one high half for each bit.
   localparam int NIB_STEPS = NIB_BITS * 2 * NIB_HALF_CYC;
   // Width of the sequencer step counter.
   localparam int NIB_CNT_W = $clog2(NIB_STEPS);
   // Values after reset.
   localparam logic RST_FLAG = 1'b0;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   // Sequencer states.
   typedef enum logic [0:0] {
      CCSB_SEQ_IDLE = 1'b0,
      CCSB_SEQ_RUN = 1'b1
   } ccsb_seq_e;
endpackage

//--- logic/ccsb_sideband.sv
// Summary of operation
// - Clear-channel mode: overhead flag high one bit period per overhead bit.
// - ATM mode: same output strobes while last PLCP frame bit arrives.
// - Loss-of-frame output set on declaration, cleared on in-frame.
// - Out-of-frame output set on declaration, cleared on in-frame.
// - Red alarm high while out-of-frame or loss-of-frame holds.
// - Receive overhead frame marker pulses on first Z6 bit only.
// - Cell sent strobe pulses on each transmit cell hand-off.
// - Transmit GFC input sampled at rising edge of driven GFC clock.
// - Exactly four transmit GFC clock rising edges per cell handed off while the port is idle.
// - Transmit top-bit flag pulses while MSB of nibble is expected.
// - Cell arrived strobe pulses on each receive cell acceptance.
// - Each cell accepted while the port is idle has its GFC nibble shifted out serially.
// - Receive GFC bits change on clock rising edges; pulses let logic latch.
// - Receive top-bit flag pulses with the nibble's MSB on output.
// - Delineation-lost output high while delineation lost, low when regained.
// - PLCP alarm, GFC and cell strobe outputs active only in ATM mode.
// - Transmit overhead frame marker pulses when first Z6 bit expected.
`timescale 1ns/10ps
module ccsb_sideband (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Channel configuration: high selects ATM mode, low clear-channel mode.
   input wire logic atm_mode,
   // Receive framer and PLCP events, one cycle each unless noted.
   input wire logic rx_bit_en,
   input wire logic rx_oh_bit,
   input wire logic rx_plcp_last_bit,
   input wire logic plcp_lof_declare,
   input wire logic plcp_oof_declare,
   input wire logic plcp_in_frame,
   input wire logic rx_poh_z6_first,
   input wire logic tx_poh_z6_expect,
   // Cell processor events.
   input wire logic tx_cell_handoff,
   input wire logic rx_cell_accept,
   input wire logic [3:0] rx_cell_gfc,
   input wire logic delineation_lost,
   // Transmit GFC pin from the far end.
   input wire logic tx_flow_nibble_in,
   // Collected transmit nibble towards the cell processor.
   output logic [3:0] tx_gfc_nibble,
   output logic tx_gfc_valid,
   // Receive PLCP and framer outputs.
   output logic rx_overhead_bit_flag,
   output logic rx_plcp_loss_frame_out,
   output logic rx_plcp_out_of_frame_out,
   output logic rx_plcp_red_alarm_out,
   output logic rx_path_overhead_frame_marker,
   output logic tx_path_overhead_frame_marker,
   // Cell strobes and delineation.
   output logic cell_sent_strobe,
   output logic cell_arrived_strobe,
   output logic cell_delineation_lost_out,
   // Transmit GFC port.
   output logic tx_flow_nibble_clock,
   output logic tx_flow_nibble_top_bit_flag,
   // Receive GFC port.
   output logic rx_flow_nibble_out,
   output logic rx_flow_nibble_clock,
   output logic rx_flow_nibble_top_bit_flag
);
   localparam int CW = ccsb_pkg::NIB_CNT_W;
   localparam int HB = $clog2(ccsb_pkg::NIB_HALF_CYC) + 1;

   // ========================================================================
   // Receive PLCP and overhead indications.
   logic oh_flag_r;
   logic lof_r;
   logic oof_r;
   logic red_r;
   logic rx_mark_r;
   logic tx_mark_r;
   logic oh_src;
   logic lof_nxt;
   logic oof_nxt;

   // The shared pin follows the mode: overhead bits or PLCP frame end.
   assign oh_src = atm_mode ? rx_plcp_last_bit : rx_oh_bit;
   // A declaration in the same cycle as in-frame wins: the alarm is safer.
   assign lof_nxt = plcp_lof_declare | (lof_r & ~plcp_in_frame);
   assign oof_nxt = plcp_oof_declare | (oof_r & ~plcp_in_frame);

   // The flag is refreshed only on bit enables, so it lasts one bit period.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         oh_flag_r <= ccsb_pkg::RST_FLAG;
      end else if (rx_bit_en) begin
         oh_flag_r <= oh_src;
      end
   end

   // Alarm and marker registers, forced low outside ATM mode.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lof_r <= ccsb_pkg::RST_FLAG;
         oof_r <= ccsb_pkg::RST_FLAG;
         red_r <= ccsb_pkg::RST_FLAG;
         rx_mark_r <= ccsb_pkg::RST_FLAG;
         tx_mark_r <= ccsb_pkg::RST_FLAG;
      end else begin
         lof_r <= atm_mode & lof_nxt;
         oof_r <= atm_mode & oof_nxt;
         red_r <= atm_mode & (lof_nxt | oof_nxt);
         rx_mark_r <= atm_mode & rx_poh_z6_first;
         tx_mark_r <= atm_mode & tx_poh_z6_expect;
      end
   end

   // ========================================================================
   // Cell strobes and delineation.
   logic sent_r;
   logic arrived_r;
   logic lcd_r;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sent_r <= ccsb_pkg::RST_FLAG;
         arrived_r <= ccsb_pkg::RST_FLAG;
         lcd_r <= ccsb_pkg::RST_FLAG;
      end else begin
         sent_r <= atm_mode & tx_cell_handoff;
         arrived_r <= atm_mode & rx_cell_accept;
         lcd_r <= atm_mode & delineation_lost;
      end
   end

   // ========================================================================
   // Transmit GFC port.
   logic tx_busy;
   logic tx_last;
   logic [CW-1:0] tx_step;
   logic tx_start;
   logic tx_clk_r;
   logic tx_msb_r;
   logic tx_pin_s1_r;
   logic tx_pin_s2_r;
   logic tx_rise_d1_r;
   logic tx_rise_d2_r;
   logic tx_rise;
   logic [3:0] tx_shift_r;
   logic [2:0] tx_taken_r;
   logic [3:0] tx_nib_r;
   logic tx_valid_r;
   logic tx_high_half;
   logic tx_first_bit;

   assign tx_start = atm_mode & tx_cell_handoff;
   // The step counter's top bits give the slot, the next bit its half.
   assign tx_high_half = tx_busy & tx_step[HB-1];
   assign tx_first_bit = tx_busy & (tx_step[CW-1:HB] == '0);
   // A rising edge leaves the pin when the high half first shows.
   assign tx_rise = tx_clk_r & ~tx_rise_d1_r;

   ccsb_nib_seq #(
      .STEPS(ccsb_pkg::NIB_STEPS),
      .CNT_W(CW)
   ) u_tx_seq (
      .clk(clk),
      .nrst(nrst),
      .start(tx_start),
      .busy(tx_busy),
      .step(tx_step),
      .last(tx_last)
   );

   // Four high halves per nibble give exactly four rising edges.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_clk_r <= ccsb_pkg::RST_FLAG;
         tx_msb_r <= ccsb_pkg::RST_FLAG;
      end else begin
         tx_clk_r <= atm_mode & tx_high_half;
         tx_msb_r <= atm_mode & tx_first_bit;
      end
   end

   // The pin is foreign, so it is synchronised over two cycles; the rise marker is delayed
   // by one cycle only, so it samples the bit the far end held just before the edge.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_pin_s1_r <= ccsb_pkg::RST_FLAG;
         tx_pin_s2_r <= ccsb_pkg::RST_FLAG;
         tx_rise_d1_r <= ccsb_pkg::RST_FLAG;
         tx_rise_d2_r <= ccsb_pkg::RST_FLAG;
      end else begin
         tx_pin_s1_r <= tx_flow_nibble_in;
         tx_pin_s2_r <= tx_pin_s1_r;
         tx_rise_d1_r <= tx_clk_r;
         tx_rise_d2_r <= tx_rise;
      end
   end

   // Bits shift in MSB first; the fourth completes the nibble.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_shift_r <= ccsb_pkg::RST_NIBBLE;
         tx_taken_r <= 3'h0;
         tx_nib_r <= ccsb_pkg::RST_NIBBLE;
         tx_valid_r <= ccsb_pkg::RST_FLAG;
      end else begin
         tx_valid_r <= 1'b0;
         if (tx_start & ~tx_busy) begin
            tx_taken_r <= 3'h0;
         end else if (tx_rise_d2_r) begin
            tx_shift_r <= {tx_shift_r[2:0], tx_pin_s2_r};
            if (tx_taken_r == 3'h3) begin
               tx_nib_r <= {tx_shift_r[2:0], tx_pin_s2_r};
               tx_valid_r <= 1'b1;
               tx_taken_r <= 3'h0;
            end else begin
               tx_taken_r <= tx_taken_r + 3'h1;
            end
         end
      end
   end

   // ========================================================================
   // Receive GFC port.
   logic rx_busy;
   logic rx_last;
   logic [CW-1:0] rx_step;
   logic rx_start;
   logic [3:0] rx_hold_r;
   logic rx_clk_r;
   logic rx_data_r;
   logic rx_msb_r;
   logic rx_high_half;
   logic [1:0] rx_slot;
   logic rx_bit_sel;

   assign rx_start = atm_mode & rx_cell_accept & ~rx_busy;
   assign rx_high_half = rx_busy & rx_step[HB-1];
   assign rx_slot = rx_step[CW-1:HB];
   // Slot 0 carries bit 3 so the nibble leaves MSB first.
   assign rx_bit_sel = rx_hold_r[2'd3 - rx_slot];

   ccsb_nib_seq #(
      .STEPS(ccsb_pkg::NIB_STEPS),
      .CNT_W(CW)
   ) u_rx_seq (
      .clk(clk),
      .nrst(nrst),
      .start(rx_start),
      .busy(rx_busy),
      .step(rx_step),
      .last(rx_last)
   );

   // The nibble is held while it shifts so a new cell cannot corrupt it.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_hold_r <= ccsb_pkg::RST_NIBBLE;
      end else if (rx_start) begin
         rx_hold_r <= rx_cell_gfc;
      end
   end

   // Data and MSB flag change together with the clock's rising edge and
   // hold for the whole bit, so the far end can latch on the falling edge.
   // The last bit is kept through the final low half, or it would vanish
   // at the very edge on which the far end latches it.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_clk_r <= ccsb_pkg::RST_FLAG;
         rx_data_r <= ccsb_pkg::RST_FLAG;
         rx_msb_r <= ccsb_pkg::RST_FLAG;
      end else begin
         rx_clk_r <= atm_mode & rx_high_half;
         if (!atm_mode || (!rx_busy && !rx_clk_r)) begin
            rx_data_r <= 1'b0;
            rx_msb_r <= 1'b0;
         end else if (rx_high_half && !rx_clk_r) begin
            rx_data_r <= rx_bit_sel;
            rx_msb_r <= (rx_slot == 2'd0);
         end
      end
   end

   // ========================================================================
   // Output assignments.
   assign rx_overhead_bit_flag = oh_flag_r;
   assign rx_plcp_loss_frame_out = lof_r;
   assign rx_plcp_out_of_frame_out = oof_r;
   assign rx_plcp_red_alarm_out = red_r;
   assign rx_path_overhead_frame_marker = rx_mark_r;
   assign tx_path_overhead_frame_marker = tx_mark_r;
   assign cell_sent_strobe = sent_r;
   assign cell_arrived_strobe = arrived_r;
   assign cell_delineation_lost_out = lcd_r;
   assign tx_flow_nibble_clock = tx_clk_r;
   assign tx_flow_nibble_top_bit_flag = tx_msb_r;
   assign tx_gfc_nibble = tx_nib_r;
   assign tx_gfc_valid = tx_valid_r;
   assign rx_flow_nibble_out = rx_data_r;
   assign rx_flow_nibble_clock = rx_clk_r;
   assign rx_flow_nibble_top_bit_flag = rx_msb_r;

   // ========================================================================
   // Assertions.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Counts transmit clock rises inside one nibble.
   logic [2:0] tx_rise_cnt_r;
   always_ff @(posedge clk) begin
      if (!nrst || !tx_busy) begin
         tx_rise_cnt_r <= 3'h0;
      end else if (tx_high_half && !tx_clk_r) begin
         tx_rise_cnt_r <= tx_rise_cnt_r + 3'h1;
      end
   end

   AST_OH_FLAG_MODE: assert property (
      (rx_bit_en && !atm_mode && rx_oh_bit) |=> rx_overhead_bit_flag)
      else $error("Overhead flag missed an overhead bit.");
   AST_FRAME_END: assert property (
      (rx_bit_en && atm_mode && rx_plcp_last_bit) |=> rx_overhead_bit_flag)
      else $error("Frame end strobe missed the last bit.");
   AST_LOF_HOLD: assert property (
      (rx_plcp_loss_frame_out && !plcp_in_frame && atm_mode)
      |=> rx_plcp_loss_frame_out)
      else $error("Loss of frame dropped before in-frame.");
   AST_OOF_CLEAR: assert property (
      (plcp_in_frame && !plcp_oof_declare) |=> !rx_plcp_out_of_frame_out)
      else $error("Out of frame not cleared on in-frame.");
   AST_RED: assert property (
      rx_plcp_red_alarm_out == (rx_plcp_loss_frame_out | rx_plcp_out_of_frame_out))
      else $error("Red alarm disagrees with frame alarms.");
   AST_SENT: assert property (
      (atm_mode && tx_cell_handoff) |=> cell_sent_strobe)
      else $error("Cell sent strobe missing.");
   AST_TX_FOUR: assert property (
      (tx_busy && tx_last) |=> (tx_rise_cnt_r == 3'h4) || !atm_mode)
      else $error("Transmit nibble clock did not give four rises.");
   AST_TX_MSB: assert property (
      $rose(tx_flow_nibble_top_bit_flag) |-> ##[0:2] tx_flow_nibble_clock)
      else $error("Top bit flag not followed by a clock rise.");
   AST_RX_MSB: assert property (
      (atm_mode && rx_start) |-> ##3 (rx_flow_nibble_top_bit_flag
         && rx_flow_nibble_out == $past(rx_cell_gfc[3], 3)))
      else $error("Receive MSB not presented with its flag.");
   AST_CLEAR_QUIET: assert property (
      !atm_mode |=> !cell_sent_strobe && !rx_flow_nibble_clock
         && !rx_plcp_red_alarm_out)
      else $error("ATM output active in clear-channel mode.");
   AST_LCD: assert property (
      delineation_lost && atm_mode |=> cell_delineation_lost_out)
      else $error("Delineation lost not shown.");

   COV_TX_NIBBLE: cover property (tx_start ##[1:20] tx_gfc_valid);
   COV_RX_NIBBLE: cover property (rx_start ##[1:20] rx_last);
   COV_RED: cover property ($rose(rx_plcp_red_alarm_out));
endmodule // ccsb_sideband

//--- verif/ccsb_far_end.sv
`timescale 1ns/10ps
// ==========================================
// Far-end logic: feeds transmit nibbles and latches received ones.
module ccsb_far_end (
   // Clock and mode.
   input wire logic clk,
   input wire logic atm_mode,
   // Transmit nibble port.
   input wire logic [3:0] tx_nib,
   input wire logic tx_flow_nibble_clock,
   input wire logic tx_flow_nibble_top_bit_flag,
   output logic tx_flow_nibble_in,
   // Receive nibble port.
   input wire logic rx_flow_nibble_out,
   input wire logic rx_flow_nibble_clock,
   input wire logic rx_flow_nibble_top_bit_flag,
   output logic [3:0] rx_nib,
   output logic [7:0] rx_nib_cnt
);
   logic [2:0] tx_idx_r = 3'h4;
   logic tx_clk_r = 1'b0;
   logic rx_clk_r = 1'b0;
   logic [2:0] rx_idx_r = 3'h0;
   logic [3:0] rx_sh_r = 4'h0;
   logic [3:0] rx_nib_r = 4'h0;
   logic [7:0] rx_cnt_r = 8'h0;
   logic [1:0] tx_sel;
   // Collected nibble and count, each from a single process.
   assign rx_nib = rx_nib_r;
   assign rx_nib_cnt = rx_cnt_r;
   // The next MSB waits on the pin between nibbles, since the index restarts only on the first rise,
   // a cycle after the top-bit flag rises, and the design samples the bit held just before that rise.
   assign tx_sel = tx_idx_r[2] ? 2'h0 : tx_idx_r[1:0];
   assign tx_flow_nibble_in = atm_mode & tx_nib[2'h3 - tx_sel];
   // Mid-cycle sampling keeps the model clear of the design's own edge.
   always @(negedge clk) begin
      if (tx_flow_nibble_clock && tx_flow_nibble_top_bit_flag) begin
         tx_idx_r <= 3'h0;
      end else if (tx_clk_r && !tx_flow_nibble_clock && !tx_idx_r[2]) begin
         tx_idx_r <= tx_idx_r + 3'h1;
      end
      tx_clk_r <= tx_flow_nibble_clock;
      rx_clk_r <= rx_flow_nibble_clock;
      // Receive bits are latched as the clock falls, MSB first from the flag.
      if (rx_clk_r && !rx_flow_nibble_clock) begin
         if (rx_flow_nibble_top_bit_flag) begin
            rx_sh_r <= {3'h0, rx_flow_nibble_out};
            rx_idx_r <= 3'h1;
         end else begin
            rx_sh_r <= {rx_sh_r[2:0], rx_flow_nibble_out};
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == 3'h3) begin
               rx_nib_r <= {rx_sh_r[2:0], rx_flow_nibble_out};
               rx_cnt_r <= rx_cnt_r + 8'h1;
            end
         end
      end
   end
endmodule // ccsb_far_end

//--- verif/tb.sv
`timescale 1ns/10ps
// ==========================================
// Bench for the cell sideband ports.
module tb;
   logic clk = 1'b0, nrst = 1'b0, atm_mode = 1'b1, rx_bit_en = 1'b0, rx_oh_bit = 1'b0;
   logic rx_plcp_last_bit = 1'b0, plcp_lof_declare = 1'b0, plcp_oof_declare = 1'b0;
   logic plcp_in_frame = 1'b0, rx_poh_z6_first = 1'b0, tx_poh_z6_expect = 1'b0;
   logic tx_cell_handoff = 1'b0, rx_cell_accept = 1'b0, delineation_lost = 1'b0;
   logic [3:0] rx_cell_gfc = 4'h0, tx_nib = 4'h0;
   logic [3:0] tx_gfc_nibble, rx_nib;
   logic [7:0] rx_nib_cnt;
   logic tx_flow_nibble_in, tx_gfc_valid, rx_overhead_bit_flag, rx_plcp_loss_frame_out;
   logic rx_plcp_out_of_frame_out, rx_plcp_red_alarm_out, rx_path_overhead_frame_marker;
   logic tx_path_overhead_frame_marker, cell_sent_strobe, cell_arrived_strobe;
   logic cell_delineation_lost_out, tx_flow_nibble_clock, tx_flow_nibble_top_bit_flag;
   logic rx_flow_nibble_out, rx_flow_nibble_clock, rx_flow_nibble_top_bit_flag;
   int mismatches = 0, checks_done = 0, cycles = 0;
   wire logic [14:0] flags = {tx_gfc_valid, rx_overhead_bit_flag, rx_plcp_loss_frame_out,
      rx_plcp_out_of_frame_out, rx_plcp_red_alarm_out, rx_path_overhead_frame_marker,
      tx_path_overhead_frame_marker, cell_sent_strobe, cell_arrived_strobe,
      cell_delineation_lost_out, tx_flow_nibble_clock, tx_flow_nibble_top_bit_flag,
      rx_flow_nibble_out, rx_flow_nibble_clock, rx_flow_nibble_top_bit_flag};

   ccsb_sideband u_ccsb_sideband (.clk, .nrst, .atm_mode, .rx_bit_en, .rx_oh_bit,
      .rx_plcp_last_bit, .plcp_lof_declare, .plcp_oof_declare, .plcp_in_frame,
      .rx_poh_z6_first, .tx_poh_z6_expect, .tx_cell_handoff, .rx_cell_accept, .rx_cell_gfc,
      .delineation_lost, .tx_flow_nibble_in, .tx_gfc_nibble, .tx_gfc_valid,
      .rx_overhead_bit_flag, .rx_plcp_loss_frame_out, .rx_plcp_out_of_frame_out,
      .rx_plcp_red_alarm_out, .rx_path_overhead_frame_marker, .tx_path_overhead_frame_marker,
      .cell_sent_strobe, .cell_arrived_strobe, .cell_delineation_lost_out,
      .tx_flow_nibble_clock, .tx_flow_nibble_top_bit_flag, .rx_flow_nibble_out,
      .rx_flow_nibble_clock, .rx_flow_nibble_top_bit_flag);
   ccsb_far_end u_ccsb_far_end (.clk, .atm_mode, .tx_nib, .tx_flow_nibble_clock,
      .tx_flow_nibble_top_bit_flag, .tx_flow_nibble_in, .rx_flow_nibble_out,
      .rx_flow_nibble_clock, .rx_flow_nibble_top_bit_flag, .rx_nib, .rx_nib_cnt);

   // A 100 ns clock, with a cycle ceiling that stops a hung run.
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         finish_test;
      end
   end

   // ==========================================
   // Helpers: inputs move 1 ns after the edge, so outputs are settled then too.
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================
   // Scenarios.
   task automatic t_reset;
      for (int i = 0; i < 15; i++) begin
         chk_bit(flags[i], ccsb_pkg::RST_FLAG);
      end
      chk_nib(tx_gfc_nibble, ccsb_pkg::RST_NIBBLE);
      $display("reset test done");
   endtask
   // The flag is a level held for a whole bit period, not a one-cycle pulse.
   task automatic t_overhead;
      atm_mode = 1'b0;
      rx_bit_en = 1'b1;
      rx_oh_bit = 1'b1;
      tick;
      rx_bit_en = 1'b0;
      rx_oh_bit = 1'b0;
      chk_bit(rx_overhead_bit_flag, 1'b1);
      tick;
      chk_bit(rx_overhead_bit_flag, 1'b1);
      rx_bit_en = 1'b1;
      tick;
      chk_bit(rx_overhead_bit_flag, 1'b0);
      atm_mode = 1'b1;
      rx_plcp_last_bit = 1'b1;
      tick;
      rx_plcp_last_bit = 1'b0;
      rx_oh_bit = 1'b1;
      chk_bit(rx_overhead_bit_flag, 1'b1);
      tick;
      rx_bit_en = 1'b0;
      rx_oh_bit = 1'b0;
      chk_bit(rx_overhead_bit_flag, 1'b0);
      $display("overhead test done");
   endtask
   // A declaration in the same cycle as in-frame must win.
   task automatic t_alarms;
      plcp_lof_declare = 1'b1;
      tick;
      plcp_lof_declare = 1'b0;
      chk_bit(rx_plcp_loss_frame_out, 1'b1);
      chk_bit(rx_plcp_out_of_frame_out, 1'b0);
      chk_bit(rx_plcp_red_alarm_out, 1'b1);
      plcp_oof_declare = 1'b1;
      tick;
      plcp_oof_declare = 1'b0;
      chk_bit(rx_plcp_out_of_frame_out, 1'b1);
      plcp_in_frame = 1'b1;
      tick;
      chk_bit(rx_plcp_loss_frame_out, 1'b0);
      chk_bit(rx_plcp_out_of_frame_out, 1'b0);
      chk_bit(rx_plcp_red_alarm_out, 1'b0);
      plcp_oof_declare = 1'b1;
      tick;
      plcp_oof_declare = 1'b0;
      chk_bit(rx_plcp_out_of_frame_out, 1'b1);
      chk_bit(rx_plcp_red_alarm_out, 1'b1);
      tick;
      plcp_in_frame = 1'b0;
      chk_bit(rx_plcp_red_alarm_out, 1'b0);
      atm_mode = 1'b0;
      plcp_lof_declare = 1'b1;
      tick;
      plcp_lof_declare = 1'b0;
      chk_bit(rx_plcp_loss_frame_out, 1'b0);
      chk_bit(rx_plcp_red_alarm_out, 1'b0);
      atm_mode = 1'b1;
      plcp_in_frame = 1'b1;
      tick;
      plcp_in_frame = 1'b0;
      chk_bit(rx_plcp_loss_frame_out, 1'b0);
      $display("alarm test done");
   endtask
   // Marker, cell and delineation events at once, in ATM mode and then in clear-channel mode.
   task automatic t_strobes;
      logic any;
      for (int m = 1; m >= 0; m--) begin
         atm_mode = m[0];
         tick;
         {rx_poh_z6_first, tx_poh_z6_expect, tx_cell_handoff, rx_cell_accept} = 4'hf;
         delineation_lost = 1'b1;
         tick;
         {rx_poh_z6_first, tx_poh_z6_expect, tx_cell_handoff, rx_cell_accept} = 4'h0;
         chk_bit(rx_path_overhead_frame_marker, m[0]);
         chk_bit(tx_path_overhead_frame_marker, m[0]);
         chk_bit(cell_sent_strobe, m[0]);
         chk_bit(cell_arrived_strobe, m[0]);
         chk_bit(cell_delineation_lost_out, m[0]);
         tick;
         delineation_lost = 1'b0;
         chk_bit(rx_path_overhead_frame_marker, 1'b0);
         chk_bit(cell_sent_strobe, 1'b0);
         any = 1'b0;
         for (int i = 0; i < 10; i++) begin
            tick;
            any = any | tx_flow_nibble_clock | rx_flow_nibble_clock;
         end
         chk_bit(cell_delineation_lost_out, 1'b0);
         chk_bit(any, m[0]);
      end
      atm_mode = 1'b1;
      $display("strobe test done");
   endtask
   // A second hand-off lands while busy and must not add clock edges.
   task automatic t_tx_gfc;
      logic [3:0] nibs [2] = '{4'h9, 4'h6};
      logic [3:0] rises, seen, got;
      logic prev;
      for (int k = 0; k < 2; k++) begin
         tx_nib = nibs[k];
         tick;
         tx_cell_handoff = 1'b1;
         tick;
         tx_cell_handoff = 1'b0;
         tick;
         chk_bit(tx_flow_nibble_clock, 1'b0);
         chk_bit(tx_flow_nibble_top_bit_flag, 1'b1);
         rises = 4'h0;
         prev = 1'b0;
         seen = 4'h0;
         got = 4'h0;
         for (int i = 0; i < 16; i++) begin
            tx_cell_handoff = (i == 0);
            tick;
            if (tx_flow_nibble_clock && !prev) begin
               rises++;
               chk_bit(tx_flow_nibble_top_bit_flag, rises == 4'h1);
            end
            prev = tx_flow_nibble_clock;
            if (tx_gfc_valid === 1'b1) begin
               seen++;
               got = tx_gfc_nibble;
            end
         end
         chk_nib(rises, 4'h4);
         chk_nib(seen, 4'h1);
         chk_nib(got, nibs[k]);
      end
      $display("transmit nibble test done");
   endtask
   // An accept while busy still strobes but its nibble is dropped.
   task automatic t_rx_gfc;
      logic [3:0] nibs [2] = '{4'ha, 4'h5};
      logic [7:0] cnt0;
      for (int k = 0; k < 2; k++) begin
         cnt0 = rx_nib_cnt;
         rx_cell_gfc = nibs[k];
         rx_cell_accept = 1'b1;
         tick;
         rx_cell_accept = 1'b0;
         chk_bit(cell_arrived_strobe, 1'b1);
         tick;
         chk_bit(rx_flow_nibble_clock, 1'b0);
         rx_cell_gfc = ~nibs[k];
         rx_cell_accept = 1'b1;
         tick;
         rx_cell_accept = 1'b0;
         chk_bit(rx_flow_nibble_clock, 1'b1);
         chk_bit(rx_flow_nibble_top_bit_flag, 1'b1);
         chk_bit(rx_flow_nibble_out, nibs[k][3]);
         chk_bit(cell_arrived_strobe, 1'b1);
         repeat (8) tick;
         chk_bit(rx_flow_nibble_out, 1'b0);
         chk_bit(rx_flow_nibble_top_bit_flag, 1'b0);
         chk_nib(rx_nib, nibs[k]);
         chk_bit(rx_nib_cnt == cnt0 + 8'h1, 1'b1);
         repeat (3) tick;
      end
      $display("receive nibble test done");
   endtask

   // Main sequence: 20 cycles of reset, then each scenario in turn.
   initial begin
      repeat (20) @(posedge clk);
      #1;
      t_reset;
      nrst = 1'b1;
      tick;
      t_overhead;
      t_alarms;
      t_strobes;
      t_tx_gfc;
      t_rx_gfc;
      finish_test;
   end
endmodule // tb
